/* File: src/tppi_pkg.sv */
// Package for the two-port pin integration block: register map, reset values, widths.
// Assumes a classic Wishbone slave with 8-bit data and byte addresses.
package tppi_pkg;
   localparam int unsigned TPPI_AW = 4;
   localparam int unsigned TPPI_DW = 8;
   // Register byte offsets
   localparam logic [3:0] TPPI_T_DATA = 4'h0;
   localparam logic [3:0] TPPI_T_PIN = 4'h1;
   localparam logic [3:0] TPPI_T_DIR = 4'h2;
   localparam logic [3:0] TPPI_T_RDRV = 4'h3;
   localparam logic [3:0] TPPI_T_PULLEN = 4'h4;
   localparam logic [3:0] TPPI_T_PULLPOL = 4'h5;
   localparam logic [3:0] TPPI_S_DATA = 4'h8;
   localparam logic [3:0] TPPI_S_PIN = 4'h9;
   localparam logic [3:0] TPPI_S_DIR = 4'hA;
   localparam logic [3:0] TPPI_S_RDRV = 4'hB;
   localparam logic [3:0] TPPI_S_PULLEN = 4'hC;
   localparam logic [3:0] TPPI_S_PULLPOL = 4'hD;
   localparam logic [3:0] TPPI_S_ODSEL = 4'hE;
   localparam logic [3:0] TPPI_ROUTE = 4'hF;
   // Reset values
   localparam logic [7:0] TPPI_RST_ZERO = 8'h00;
   localparam logic [7:0] TPPI_RST_S_PULLEN = 8'hFF;
   // Bit position of the SPI routing control in the routing register
   localparam int unsigned TPPI_ROUTE_SPI_BIT = 0;
endpackage : tppi_pkg

/* File: src/tppi_top.sv */
// Pin integration for a timer-shared port and a serial-shared port, 8 pins each.
// Assumes a classic Wishbone master on clk_i; peripherals supply enables and output levels.
// Summary of operation
// - Active timer function overrides GPIO on the timer port.
// - Enabled timer output compare channels drive their timer port pins.
// - During reset all timer port pins are undriven inputs.
// - Data read returns latch where direction is 1, else sampled pin.
// - Input register always returns sampled pins; writes ignored.
// - Direction bit 0 means input, 1 means output.
// - Output compare forces output without altering the stored direction bit.
// - Disabled output compare returns pin direction to the stored bit.
// - Input capture sees every timer pin level, even when output.
// - Reduced drive: 0 full, 1 about one sixth; ignored for inputs.
// - Timer pull enable only for inputs; reset disables all timer pulls.
// - Polarity picks pull-up or pull-down when pull enabled and allowed.
// - Enabled SPI and SCI functions beat GPIO on the serial port.
// - SPI enabled: upper pins are select, clock, MOSI, MISO; direction ignored.
// - SCI transmit forces output, receive forces input; pins 3/2 and 1/0.
// - Disabled serial functions return direction control to stored bits.
// - During reset serial pins are inputs with pull-up; pull enables reset set.
// - Serial pull-up works for inputs and open-drain outputs, pull-down for inputs only.
// - SPI pins relocatable away from the serial port by a routing setting.
// - Open-drain select: 0 push-pull, 1 open-drain, high never driven.
`timescale 1ns/1ps
module tppi_top (
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [tppi_pkg::TPPI_AW-1:0] wb_adr_i,
   input wire logic [tppi_pkg::TPPI_DW-1:0] wb_dat_i,
   input wire logic [0:0] wb_sel_i,
   output logic [tppi_pkg::TPPI_DW-1:0] wb_dat_o,
   output logic wb_ack_o,
   // Timer unit
   input wire logic tmr_en_i,
   input wire logic [7:0] tmr_oc_en_i,
   input wire logic [7:0] tmr_oc_level_i,
   output logic [7:0] tmr_capture_o,
   // Serial peripheral unit: slave_select, clock, mosi, miso at bits 3..0
   input wire logic spi_en_i,
   input wire logic [3:0] spi_oe_i,
   input wire logic [3:0] spi_out_i,
   output logic [3:0] spi_in_o,
   output logic spi_routed_away_o,
   // Async serial units
   input wire logic async_serial_unit_zero_tx_en_i,
   input wire logic async_serial_unit_zero_rx_en_i,
   input wire logic async_serial_unit_zero_tx_i,
   output logic async_serial_unit_zero_rx_o,
   input wire logic async_serial_unit_one_tx_en_i,
   input wire logic async_serial_unit_one_rx_en_i,
   input wire logic async_serial_unit_one_tx_i,
   output logic async_serial_unit_one_rx_o,
   // Timer-shared pins
   input wire logic [7:0] tpin_i,
   output logic [7:0] tpin_o,
   output logic [7:0] tpin_oe_n_o,
   output logic [7:0] tpin_reduced_o,
   output logic [7:0] tpin_pull_up_o,
   output logic [7:0] tpin_pull_down_o,
   // Serial-shared pins
   input wire logic [7:0] spin_i,
   output logic [7:0] spin_o,
   output logic [7:0] spin_oe_n_o,
   output logic [7:0] spin_reduced_o,
   output logic [7:0] spin_pull_up_o,
   output logic [7:0] spin_pull_down_o
);
   import tppi_pkg::*;

   logic [7:0] t_data_r, t_dir_r, t_rdrv_r, t_pullen_r, t_pullpol_r;
   logic [7:0] s_data_r, s_dir_r, s_rdrv_r, s_pullen_r, s_pullpol_r, s_od_r;
   logic [7:0] route_r;
   logic [7:0] t_meta_r, t_sync_r, s_meta_r, s_sync_r;
   logic ack_r;
   logic [7:0] dat_r;
   logic [7:0] t_out_en, t_out_val, s_out_en, s_out_val, s_drive_en;
   logic [7:0] rd_nxt;
   logic wr_ok, spi_here;

   // Pin synchronisers
   always_ff @(posedge clk_i) begin
      t_meta_r <= tpin_i;
      t_sync_r <= t_meta_r;
      s_meta_r <= spin_i;
      s_sync_r <= s_meta_r;
   end

   // Bus handshake: one wait state, ack drops after one cycle
   assign wr_ok = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & ~ack_r;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
      end
   end

   // Timer port registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         t_data_r <= TPPI_RST_ZERO;
         t_dir_r <= TPPI_RST_ZERO;
         t_rdrv_r <= TPPI_RST_ZERO;
         t_pullen_r <= TPPI_RST_ZERO;
         t_pullpol_r <= TPPI_RST_ZERO;
      end else if (wr_ok) begin
         unique case (wb_adr_i)
            TPPI_T_DATA: t_data_r <= wb_dat_i;
            TPPI_T_DIR: t_dir_r <= wb_dat_i;
            TPPI_T_RDRV: t_rdrv_r <= wb_dat_i;
            TPPI_T_PULLEN: t_pullen_r <= wb_dat_i;
            TPPI_T_PULLPOL: t_pullpol_r <= wb_dat_i;
            default: ;
         endcase
      end
   end

   // Serial port registers and routing
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_data_r <= TPPI_RST_ZERO;
         s_dir_r <= TPPI_RST_ZERO;
         s_rdrv_r <= TPPI_RST_ZERO;
         s_pullen_r <= TPPI_RST_S_PULLEN;
         s_pullpol_r <= TPPI_RST_ZERO;
         s_od_r <= TPPI_RST_ZERO;
         route_r <= TPPI_RST_ZERO;
      end else if (wr_ok) begin
         unique case (wb_adr_i)
            TPPI_S_DATA: s_data_r <= wb_dat_i;
            TPPI_S_DIR: s_dir_r <= wb_dat_i;
            TPPI_S_RDRV: s_rdrv_r <= wb_dat_i;
            TPPI_S_PULLEN: s_pullen_r <= wb_dat_i;
            TPPI_S_PULLPOL: s_pullpol_r <= wb_dat_i;
            TPPI_S_ODSEL: s_od_r <= wb_dat_i;
            TPPI_ROUTE: route_r <= wb_dat_i;
            default: ;
         endcase
      end
   end

   // Read multiplexer
   always_comb begin
      rd_nxt = 8'h00;
      unique case (wb_adr_i)
         TPPI_T_DATA: rd_nxt = (t_dir_r & t_data_r) | (~t_dir_r & t_sync_r);
         TPPI_T_PIN: rd_nxt = t_sync_r;
         TPPI_T_DIR: rd_nxt = t_dir_r;
         TPPI_T_RDRV: rd_nxt = t_rdrv_r;
         TPPI_T_PULLEN: rd_nxt = t_pullen_r;
         TPPI_T_PULLPOL: rd_nxt = t_pullpol_r;
         TPPI_S_DATA: rd_nxt = (s_dir_r & s_data_r) | (~s_dir_r & s_sync_r);
         TPPI_S_PIN: rd_nxt = s_sync_r;
         TPPI_S_DIR: rd_nxt = s_dir_r;
         TPPI_S_RDRV: rd_nxt = s_rdrv_r;
         TPPI_S_PULLEN: rd_nxt = s_pullen_r;
         TPPI_S_PULLPOL: rd_nxt = s_pullpol_r;
         TPPI_S_ODSEL: rd_nxt = s_od_r;
         TPPI_ROUTE: rd_nxt = route_r;
         default: rd_nxt = 8'h00;
      endcase
   end

   // Read data register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_r <= 8'h00;
      end else if (wb_cyc_i & wb_stb_i & ~ack_r) begin
         dat_r <= rd_nxt;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;

   // Timer port direction and data selection
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (tmr_en_i & tmr_oc_en_i[i]) begin
            t_out_en[i] = 1'b1;
            t_out_val[i] = tmr_oc_level_i[i];
         end else begin
            t_out_en[i] = t_dir_r[i];
            t_out_val[i] = t_data_r[i];
         end
      end
   end

   // Timer pins; reset holds every pin undriven
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         tpin_o[i] = t_out_val[i];
         tpin_oe_n_o[i] = rst_i | ~t_out_en[i];
         tpin_reduced_o[i] = t_out_en[i] & t_rdrv_r[i] & ~rst_i;
         tpin_pull_up_o[i] = ~rst_i & ~t_out_en[i] & t_pullen_r[i] & ~t_pullpol_r[i];
         tpin_pull_down_o[i] = ~rst_i & ~t_out_en[i] & t_pullen_r[i] & t_pullpol_r[i];
      end
   end

   assign tmr_capture_o = t_sync_r;

   // SPI present on this port unless routed away
   assign spi_here = spi_en_i & ~route_r[TPPI_ROUTE_SPI_BIT];
   assign spi_routed_away_o = route_r[TPPI_ROUTE_SPI_BIT];

   // Serial port function selection
   always_comb begin
      s_out_en = s_dir_r;
      s_out_val = s_data_r;
      if (spi_here) begin
         s_out_en[7:4] = spi_oe_i;
         s_out_val[7:4] = spi_out_i;
      end
      if (async_serial_unit_one_tx_en_i) begin
         s_out_en[3] = 1'b1;
         s_out_val[3] = async_serial_unit_one_tx_i;
      end
      if (async_serial_unit_one_rx_en_i) begin
         s_out_en[2] = 1'b0;
      end
      if (async_serial_unit_zero_tx_en_i) begin
         s_out_en[1] = 1'b1;
         s_out_val[1] = async_serial_unit_zero_tx_i;
      end
      if (async_serial_unit_zero_rx_en_i) begin
         s_out_en[0] = 1'b0;
      end
   end

   // Open-drain drives only low levels
   assign s_drive_en = ~rst_i ? (s_out_en & ~(s_od_r & s_out_val)) : 8'h00;

   // Serial pins; reset gives inputs with pull-up
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         spin_o[i] = s_out_val[i];
         spin_oe_n_o[i] = ~s_drive_en[i];
         spin_reduced_o[i] = s_drive_en[i] & s_rdrv_r[i];
         if (rst_i) begin
            spin_pull_up_o[i] = 1'b1;
            spin_pull_down_o[i] = 1'b0;
         end else begin
            // Pull-up allowed for inputs and open-drain outputs, pull-down for inputs only
            spin_pull_up_o[i] = s_pullen_r[i] & ~s_pullpol_r[i] & (~s_out_en[i] | s_od_r[i]);
            spin_pull_down_o[i] = s_pullen_r[i] & s_pullpol_r[i] & ~s_out_en[i];
         end
      end
   end

   // Peripheral inputs from synchronised pin levels
   assign spi_in_o = s_sync_r[7:4];
   assign async_serial_unit_one_rx_o = s_sync_r[2];
   assign async_serial_unit_zero_rx_o = s_sync_r[0];
endmodule : tppi_top

/* File: tb/tppi_asserts.sv */
// Checker of tppi_top bus and pin behaviour, bound to every instance.
// Sees only the top ports; pin outputs are combinational.
`timescale 1ns/1ps
module tppi_asserts (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic tmr_en_i,
   input wire logic [7:0] tmr_oc_en_i,
   input wire logic [7:0] tmr_oc_level_i,
   input wire logic async_serial_unit_zero_tx_en_i,
   input wire logic async_serial_unit_zero_rx_en_i,
   input wire logic async_serial_unit_zero_tx_i,
   input wire logic [7:0] tpin_o,
   input wire logic [7:0] tpin_oe_n_o,
   input wire logic [7:0] tpin_reduced_o,
   input wire logic [7:0] tpin_pull_up_o,
   input wire logic [7:0] tpin_pull_down_o,
   input wire logic [7:0] spin_oe_n_o,
   input wire logic [7:0] spin_pull_up_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Bus request still waiting for its answer
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   // Reset state of both ports, checked while reset is held
   a_reset_t_float: assert property (disable iff (1'b0) rst_i |-> tpin_oe_n_o == 8'hFF)
      else $error("timer pin driven in reset");
   a_reset_s_pullup: assert property (disable iff (1'b0) rst_i |-> spin_pull_up_o == 8'hFF)
      else $error("serial pin not pulled up in reset");
   a_reset_t_nopull: assert property (disable iff (1'b0) rst_i |-> (tpin_pull_up_o | tpin_pull_down_o) == 8'h00)
      else $error("timer pull on in reset");
   // Bus answer timing
   a_ack_after_req: assert property (s_req |=> wb_ack_o)
      else $error("request not answered");
   a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   // Timer compare ownership of pins, pulls on inputs only, reduced drive on outputs only
   a_oc_drives_pin: assert property (tmr_en_i |-> ((tpin_oe_n_o | (tpin_o ^ tmr_oc_level_i)) & tmr_oc_en_i) == 8'h00)
      else $error("compare channel not on its pin");
   a_t_pull_input: assert property (((tpin_pull_up_o | tpin_pull_down_o) & ~tpin_oe_n_o) == 8'h00)
      else $error("timer pull on a driven pin");
   a_reduced_driving: assert property ((tpin_reduced_o & tpin_oe_n_o) == 8'h00)
      else $error("reduced drive on an input");
   // Async serial unit direction forcing
   a_sci_tx_out: assert property (async_serial_unit_zero_tx_en_i && !async_serial_unit_zero_tx_i |-> !spin_oe_n_o[1])
      else $error("transmit low not driven");
   a_sci_rx_in: assert property (async_serial_unit_zero_rx_en_i |-> spin_oe_n_o[0])
      else $error("receive pin driven");
endmodule : tppi_asserts
bind tppi_top tppi_asserts u_chk (.*);

/* File: tb/tppi_board.sv */
// Board model on one port: resolves pins from drive, pulls and a bench level.
// Fed from the pin ports of tppi_top.
`timescale 1ns/1ps
module tppi_board (
   input wire logic [7:0] out_i,
   input wire logic [7:0] oe_n_i,
   input wire logic [7:0] pu_i,
   input wire logic [7:0] pd_i,
   input wire logic [7:0] ext_i,
   output logic [7:0] pin_o
);
   // Driver wins, then pull-up, then pull-down, then outside level
   assign pin_o = (~oe_n_i & out_i) | (oe_n_i & pu_i) | (oe_n_i & ~pu_i & ~pd_i & ext_i);
endmodule : tppi_board

/* File: tb/tppi_bench.sv */
// Self-checking bench for tppi_top with a board model on each port.
// Assumes a 25 MHz clock and the package register map.
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; $display("wrong value %0t %h", $time, g); end end
module tppi_bench;
   import tppi_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, tmr_en_i = 1'b0;
   logic spi_en_i = 1'b0, async_serial_unit_zero_tx_en_i = 1'b0, async_serial_unit_zero_rx_en_i = 1'b0, async_serial_unit_zero_tx_i = 1'b0;
   logic async_serial_unit_one_tx_en_i = 1'b0, async_serial_unit_one_rx_en_i = 1'b0, async_serial_unit_one_tx_i = 1'b0;
   logic wb_ack_o, spi_routed_away_o, async_serial_unit_zero_rx_o, async_serial_unit_one_rx_o;
   logic [0:0] wb_sel_i = 1'b1;
   logic [3:0] wb_adr_i = 4'h0, spi_oe_i = 4'h0, spi_out_i = 4'h0, spi_in_o;
   logic [7:0] wb_dat_i = 8'h00, tmr_oc_en_i = 8'h00, tmr_oc_level_i = 8'h00, ext_t = 8'h3C, ext_s = 8'h00, q;
   logic [7:0] wb_dat_o, tmr_capture_o, tpin_i, tpin_o, tpin_oe_n_o, tpin_reduced_o, tpin_pull_up_o, tpin_pull_down_o;
   logic [7:0] spin_i, spin_o, spin_oe_n_o, spin_reduced_o, spin_pull_up_o, spin_pull_down_o;
   int errors = 0, total_checks = 0;
   // Rows: address, write, write data, expected read
   logic [20:0] row [14] = '{{TPPI_T_DIR, 1'b1, 8'h0F, 8'h00}, {TPPI_T_DIR, 1'b0, 8'h00, 8'h0F},
      {TPPI_T_DATA, 1'b1, 8'hA5, 8'h00}, {TPPI_T_DATA, 1'b0, 8'h00, 8'h35}, {TPPI_T_PIN, 1'b1, 8'hFF, 8'h00},
      {TPPI_T_PIN, 1'b0, 8'h00, 8'h35}, {4'h6, 1'b0, 8'h00, 8'h00}, {TPPI_T_PULLEN, 1'b0, 8'h00, 8'h00},
      {TPPI_S_PULLEN, 1'b0, 8'h00, 8'hFF}, {TPPI_S_PIN, 1'b0, 8'h00, 8'hFF}, {TPPI_S_PULLPOL, 1'b1, 8'hF0, 8'h00},
      {TPPI_S_PIN, 1'b0, 8'h00, 8'h0F}, {TPPI_T_PULLEN, 1'b1, 8'hFF, 8'h00}, {TPPI_T_PIN, 1'b0, 8'h00, 8'hF5}};
   tppi_top DUT (.*);
   tppi_board u_tb (.out_i(tpin_o), .oe_n_i(tpin_oe_n_o), .pu_i(tpin_pull_up_o), .pd_i(tpin_pull_down_o),
      .ext_i(ext_t), .pin_o(tpin_i));
   tppi_board u_sb (.out_i(spin_o), .oe_n_i(spin_oe_n_o), .pu_i(spin_pull_up_o), .pd_i(spin_pull_down_o),
      .ext_i(ext_s), .pin_o(spin_i));
   // Clock
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   // Verdict and end of run
   task automatic report_and_stop();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : report_and_stop
   // One classic bus cycle; ack and read data are taken at the rising edge that sees ack high
   task automatic wb(input logic [3:0] a, input logic w, input logic [7:0] d, output logic [7:0] r);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) begin
         errors++;
         report_and_stop();
      end
      r = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask : wb
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (row[i]) begin
         wb(row[i][20:17], row[i][16], row[i][15:8], q);
         if (!row[i][16]) `CHK(q, row[i][7:0])
         $display("row %0d done", i);
      end
      // Timer compare takes pin 7 over and gives it back
      tmr_en_i <= 1'b1;
      tmr_oc_en_i <= 8'h80;
      tmr_oc_level_i <= 8'h80;
      @(negedge clk_i);
      `CHK(tpin_oe_n_o[7], 1'b0)
      `CHK(tpin_pull_up_o[7], 1'b0)
      wb(TPPI_T_DIR, 1'b0, 8'h00, q);
      `CHK(q, 8'h0F)
      `CHK(tmr_capture_o, 8'hF5)
      tmr_oc_en_i <= 8'h00;
      @(negedge clk_i);
      `CHK(tpin_oe_n_o[7], 1'b1)
      $display("timer done");
      // Async serial unit forces direction, then receive hands it back
      wb(TPPI_S_DIR, 1'b1, 8'hFF, q);
      async_serial_unit_zero_tx_en_i <= 1'b1;
      async_serial_unit_zero_rx_en_i <= 1'b1;
      @(negedge clk_i);
      `CHK(spin_oe_n_o[1:0], 2'b01)
      `CHK(spin_o[1], 1'b0)
      @(posedge clk_i);
      async_serial_unit_zero_rx_en_i <= 1'b0;
      @(negedge clk_i);
      `CHK(spin_oe_n_o[0], 1'b0)
      // Serial peripheral unit owns the upper pins, then is routed away
      @(posedge clk_i);
      spi_en_i <= 1'b1;
      spi_oe_i <= 4'hF;
      spi_out_i <= 4'hA;
      @(negedge clk_i);
      `CHK({spin_oe_n_o[7:4], spin_o[7:4]}, 8'h0A)
      wb(TPPI_ROUTE, 1'b1, 8'h01, q);
      `CHK(spi_routed_away_o, 1'b1)
      spi_en_i <= 1'b0;
      async_serial_unit_zero_tx_en_i <= 1'b0;
      $display("serial done");
      // Open drain, reduced drive and pulls on outputs
      wb(TPPI_S_DATA, 1'b1, 8'hFF, q);
      wb(TPPI_S_RDRV, 1'b1, 8'hFF, q);
      wb(TPPI_S_ODSEL, 1'b1, 8'h01, q);
      `CHK(spin_oe_n_o[0], 1'b1)
      `CHK({spin_reduced_o[2], spin_reduced_o[0]}, 2'b10)
      `CHK({spin_pull_up_o[2], spin_pull_up_o[0]}, 2'b01)
      // Second reset in mid-run
      rst_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      `CHK({tpin_oe_n_o, spin_pull_up_o, tpin_pull_up_o}, 24'hFF_FF00)
      rst_i <= 1'b0;
      // Registers are back at their reset values after the second release
      wb(TPPI_S_PULLEN, 1'b0, 8'h00, q);
      `CHK(q, 8'hFF)
      wb(TPPI_T_DIR, 1'b0, 8'h00, q);
      `CHK(q, 8'h00)
      $display("reset done");
      report_and_stop();
   end
endmodule : tppi_bench
